// [src/rcd_top.sv]
/*
  Clock trim and divider block with its AXI4-Lite register file. Holds
  the six registers and joins the trim engine and the divider.
  Assumes the selected input clock and the counter carry arrive as
  one-cycle enables from logic on sys_clk, so neither is synchronised.
*/
// Contract
// (RULE1) Hold a 10-bit count of input ticks removed per correction period.
// (RULE2) Period 19 with amount 8 masks eight ticks in every 20 seconds.
// (RULE3) The counter gets the input clock with those ticks removed.
// (RULE4) One enable bit turns masking on; reset value 0 means uncorrected.
// (RULE5) A 4-bit ratio divides the pin clock by two to that power.
// (RULE6) Software changes the ratio only while enable and running read 0.
// (RULE7) Running bit reads 1 while dividing; when stopped the pin is low.
// (RULE8) Writing enable 1 starts, 0 stops; status follows the real state.
// (RULE9) A 6-bit field sets the period as its value plus one seconds.
// (RULE10) Select 0 sends the carry to the tick pin, 1 its halved form.
// (RULE11) Software and bus resets leave all these registers untouched.
// (RULE12) Reserved bits read zero; software writes zero to them.
// (RULE13) Software derives the amount from measured frequency and base value.
// (RULE14) To retune: clear enable, await running 0, write ratio, enable.
`timescale 1ns/1ps
module rcd_top
  import rcd_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic        soft_rst,
  input  wire logic        in_clk_tick,
  input  wire logic        carry_pulse,
  input  wire logic [4:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [4:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic             corrected_counter_clock,
  output logic             divided_clock_pin,
  output logic             counter_tick_pin
);
  typedef struct packed {
    logic                   aw_hold;
    logic [4:0]             awaddr;
    logic                   w_hold;
    logic [31:0]            wdata;
    logic [3:0]             wstrb;
    logic                   bvalid;
    logic [1:0]             bresp;
    logic                   rvalid;
    logic [4:0]             rd_addr;
    logic [31:0]            rdata;
    logic [1:0]             rresp;
    logic [CAL_AMT_W-1:0]   cal_amt;
    logic                   cal_en;
    logic [DIV_RATIO_W-1:0] div_ratio;
    logic                   div_en;
    logic [CAL_PRD_W-1:0]   cal_prd;
    logic                   tick_sel;
  } rcd_top_st_t;

  rcd_top_st_t q, d;
  rcd_ctl_if   ctl ();
  logic        commit;
  logic        ar_take;

  // True for the six decoded word addresses
  function automatic logic is_mapped(input logic [4:0] a);
    case (a)
      ADDR_CAL_AMT, ADDR_CAL_EN, ADDR_DIV_RATIO,
      ADDR_DIV_CTL, ADDR_CAL_PRD, ADDR_TICK_SEL: is_mapped = 1'b1;
      default:                                   is_mapped = 1'b0;
    endcase
  endfunction

  // Read word; narrow fields sit low and all unused bits read zero
  function automatic logic [31:0] rd_word(input logic [4:0]  a,
                                          input rcd_top_st_t s,
                                          input logic        run);
    rd_word = 32'h0000_0000; // RULE12
    case (a)
      ADDR_CAL_AMT:   rd_word[CAL_AMT_W-1:0]   = s.cal_amt;
      ADDR_CAL_EN:    rd_word[0]               = s.cal_en;
      ADDR_DIV_RATIO: rd_word[DIV_RATIO_W-1:0] = s.div_ratio;
      ADDR_DIV_CTL: begin
        rd_word[DIV_EN_BIT]  = s.div_en;
        rd_word[DIV_RUN_BIT] = run; // RULE7
      end
      ADDR_CAL_PRD:   rd_word[CAL_PRD_W-1:0]   = s.cal_prd;
      ADDR_TICK_SEL:  rd_word[0]               = s.tick_sel;
      default:        rd_word = 32'h0000_0000;
    endcase
  endfunction

  // Each address or data beat is held until its partner arrives
  assign s_axi_awready = !q.aw_hold && !q.bvalid;
  assign s_axi_wready  = !q.w_hold && !q.bvalid;
  assign s_axi_arready = !q.rvalid;
  assign commit        = q.aw_hold && q.w_hold;
  assign ar_take       = s_axi_arvalid && s_axi_arready;

  // Bus slave and register file
  always_comb begin
    d = q;
    if (s_axi_awvalid && s_axi_awready) begin
      d.aw_hold = 1'b1;
      d.awaddr  = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      d.w_hold = 1'b1;
      d.wdata  = s_axi_wdata;
      d.wstrb  = s_axi_wstrb;
    end
    if (commit) begin
      d.aw_hold = 1'b0;
      d.w_hold  = 1'b0;
      d.bvalid  = 1'b1;
      d.bresp   = is_mapped(q.awaddr) ? RESP_OKAY : RESP_SLVERR;
      // Reserved bits are dropped on write, so they always read zero
      if (q.wstrb[0]) begin
        case (q.awaddr)
          ADDR_CAL_AMT:   d.cal_amt[7:0] = q.wdata[7:0]; // RULE1
          ADDR_CAL_EN:    d.cal_en = q.wdata[0]; // RULE4
          ADDR_DIV_RATIO: d.div_ratio = q.wdata[DIV_RATIO_W-1:0]; // RULE5
          ADDR_DIV_CTL:   d.div_en = q.wdata[DIV_EN_BIT]; // RULE8
          ADDR_CAL_PRD:   d.cal_prd = q.wdata[CAL_PRD_W-1:0]; // RULE9
          ADDR_TICK_SEL:  d.tick_sel = q.wdata[0]; // RULE10
          default:        d.tick_sel = q.tick_sel;
        endcase
      end
      if (q.wstrb[1] && q.awaddr == ADDR_CAL_AMT) begin
        d.cal_amt[CAL_AMT_W-1:8] = q.wdata[CAL_AMT_W-1:8]; // RULE1
      end
    end
    if (q.bvalid && s_axi_bready) begin
      d.bvalid = 1'b0;
    end
    if (ar_take) begin
      d.rvalid  = 1'b1;
      d.rd_addr = s_axi_araddr;
      d.rdata   = rd_word(s_axi_araddr, q, ctl.div_running);
      d.rresp   = is_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
    end else if (q.rvalid && s_axi_rready) begin
      d.rvalid = 1'b0;
    end
  end

  // Only the power-on reset clears settings; soft_rst never reaches here
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      q           <= '0;
      q.cal_amt   <= CAL_AMT_RST;
      q.cal_prd   <= CAL_PRD_RST;
      q.div_ratio <= DIV_RATIO_RST;
    end else begin
      q <= d; // RULE11
    end
  end

  assign s_axi_bvalid = q.bvalid;
  assign s_axi_bresp  = q.bresp;
  assign s_axi_rvalid = q.rvalid;
  assign s_axi_rdata  = q.rdata;
  assign s_axi_rresp  = q.rresp;

  // Settings out to the engines
  assign ctl.cal_amt   = q.cal_amt;
  assign ctl.cal_en    = q.cal_en;
  assign ctl.cal_prd   = q.cal_prd;
  assign ctl.div_ratio = q.div_ratio; // RULE6
  assign ctl.div_en    = q.div_en;
  assign ctl.tick_sel  = q.tick_sel;

  // Trim engine feeding the counter
  rcd_trim u_trim (
    .sys_clk                 (sys_clk),
    .rst                     (rst),
    .soft_rst                (soft_rst),
    .in_clk_tick             (in_clk_tick),
    .carry_pulse             (carry_pulse),
    .ctl                     (ctl.trim),
    .corrected_counter_clock (corrected_counter_clock)
  );

  // Divider and tick selector; ratio is read live, so retune only stopped
  rcd_div u_div (
    .sys_clk           (sys_clk),
    .rst               (rst),
    .soft_rst          (soft_rst),
    .in_clk_tick       (in_clk_tick),
    .carry_pulse       (carry_pulse),
    .ctl               (ctl.divr),
    .divided_clock_pin (divided_clock_pin),
    .counter_tick_pin  (counter_tick_pin)
  );

  // Checks on the register file
  property p_amt_store;
    @(posedge sys_clk) disable iff (rst)
    commit && q.awaddr == ADDR_CAL_AMT && q.wstrb[1:0] == 2'h3
      |=> q.cal_amt == $past(q.wdata[CAL_AMT_W-1:0]);
  endproperty
  a_amt_store: assert property (p_amt_store) else $error("amount not stored"); // RULE1

  property p_en_store;
    @(posedge sys_clk) disable iff (rst)
    commit && q.awaddr == ADDR_CAL_EN && q.wstrb[0]
      |=> ##1 ctl.cal_en == $past(q.wdata[0], 2);
  endproperty
  a_en_store: assert property (p_en_store) else $error("enable not applied"); // RULE4

  property p_ratio_store;
    @(posedge sys_clk) disable iff (rst)
    commit && q.awaddr == ADDR_DIV_RATIO && q.wstrb[0]
      |=> q.div_ratio == $past(q.wdata[DIV_RATIO_W-1:0]);
  endproperty
  a_ratio_store: assert property (p_ratio_store) else $error("ratio not stored"); // RULE5

  property p_start;
    @(posedge sys_clk) disable iff (rst)
    commit && q.awaddr == ADDR_DIV_CTL && q.wstrb[0] && q.wdata[DIV_EN_BIT]
      && !soft_rst && !ctl.div_running ##1 !soft_rst |=> ctl.div_running;
  endproperty
  a_start: assert property (p_start) else $error("divider did not start"); // RULE8

  property p_prd_store;
    @(posedge sys_clk) disable iff (rst)
    commit && q.awaddr == ADDR_CAL_PRD && q.wstrb[0]
      |=> q.cal_prd == $past(q.wdata[CAL_PRD_W-1:0]);
  endproperty
  a_prd_store: assert property (p_prd_store) else $error("period not stored"); // RULE9

  property p_keep;
    @(posedge sys_clk) disable iff (rst)
    soft_rst && !commit
      |=> $stable(q.cal_amt) && $stable(q.cal_en) && $stable(q.div_ratio)
          && $stable(q.div_en) && $stable(q.cal_prd) && $stable(q.tick_sel);
  endproperty
  a_keep: assert property (p_keep) else $error("setting lost on soft reset"); // RULE11

  property p_rsv;
    @(posedge sys_clk) disable iff (rst)
    q.rvalid && q.rd_addr == ADDR_DIV_CTL |-> q.rdata[31:2] == 30'h0;
  endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bits not zero"); // RULE12

  property p_run_read;
    @(posedge sys_clk) disable iff (rst)
    ar_take && s_axi_araddr == ADDR_DIV_CTL
      |=> s_axi_rdata[DIV_RUN_BIT] == $past(ctl.div_running);
  endproperty
  a_run_read: assert property (p_run_read) else $error("status misread"); // RULE7

  property p_bresp_time;
    @(posedge sys_clk) disable iff (rst)
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |=> ##1 s_axi_bvalid;
  endproperty
  a_bresp_time: assert property (p_bresp_time) else $error("write answer late");

  property p_unmapped;
    @(posedge sys_clk) disable iff (rst)
    ar_take && !is_mapped(s_axi_araddr)
      |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0000_0000;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read accepted");
endmodule // rcd_top

// [pkg/rcd_pkg.sv]
/*
  Shared constants of the clock trim and divider block: register byte
  offsets, field widths and positions, reset values, bus answers, states.
  Assumes a 32-bit AXI4-Lite register bus with word-aligned registers.
*/
package rcd_pkg;
  // Register byte addresses
  localparam logic [4:0] ADDR_CAL_AMT   = 5'h00;
  localparam logic [4:0] ADDR_CAL_EN    = 5'h04;
  localparam logic [4:0] ADDR_DIV_RATIO = 5'h08;
  localparam logic [4:0] ADDR_DIV_CTL   = 5'h0C;
  localparam logic [4:0] ADDR_CAL_PRD   = 5'h10;
  localparam logic [4:0] ADDR_TICK_SEL  = 5'h14;
  // Field widths and bit positions
  localparam int CAL_AMT_W   = 10;
  localparam int CAL_PRD_W   = 6;
  localparam int DIV_RATIO_W = 4;
  localparam int DIV_CNT_W   = 15;
  localparam int DIV_EN_BIT  = 0;
  localparam int DIV_RUN_BIT = 1;
  // Reset values
  localparam logic [CAL_AMT_W-1:0]   CAL_AMT_RST   = 10'h000;
  localparam logic [CAL_PRD_W-1:0]   CAL_PRD_RST   = 6'h00;
  localparam logic [DIV_RATIO_W-1:0] DIV_RATIO_RST = 4'h0;
  // Bus answers
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Divider states, one-hot
  typedef enum logic [1:0] {
    RCD_DV_IDLE = 2'b01,
    RCD_DV_RUN  = 2'b10
  } rcd_dv_state_t;
endpackage

// [pkg/rcd_ctl_if.sv]
/*
  Configuration and status carrier between the register file and the
  two clock engines. Assumes all ends run on sys_clk.
*/
`timescale 1ns/1ps
interface rcd_ctl_if;
  import rcd_pkg::*;
  logic [CAL_AMT_W-1:0]   cal_amt;
  logic                   cal_en;
  logic [CAL_PRD_W-1:0]   cal_prd;
  logic [DIV_RATIO_W-1:0] div_ratio;
  logic                   div_en;
  logic                   div_running;
  logic                   tick_sel;
  // Register side drives settings and watches the divider state
  modport regs (output cal_amt, cal_en, cal_prd, div_ratio, div_en, tick_sel,
                input div_running);
  modport trim (input cal_amt, cal_en, cal_prd);
  modport divr (input div_ratio, div_en, tick_sel, output div_running);
endinterface // rcd_ctl_if

// [src/rcd_trim.sv]
/*
  Cycle-masking trim engine: removes a programmed number of input clock
  ticks once per programmed whole-second period.
  Assumes in_clk_tick and carry_pulse are one-cycle enables on sys_clk.
*/
`timescale 1ns/1ps
module rcd_trim
  import rcd_pkg::*;
(
  input  wire logic sys_clk,
  input  wire logic rst,
  input  wire logic soft_rst,
  input  wire logic in_clk_tick,
  input  wire logic carry_pulse,
  rcd_ctl_if.trim   ctl,
  output logic      corrected_counter_clock
);
  typedef struct packed {
    logic [CAL_PRD_W-1:0] sec_cnt;
    logic [CAL_AMT_W-1:0] budget;
    logic                 out;
  } rcd_trim_st_t;
  rcd_trim_st_t q, d;

  // Mask ticks while budget lasts, reload at each period boundary
  always_comb begin
    d = q;
    d.out = in_clk_tick & ~(ctl.cal_en & (q.budget != '0)); // RULE3 RULE4
    if (!ctl.cal_en || soft_rst) begin
      d.sec_cnt = '0;
      d.budget  = ctl.cal_amt; // RULE4
    end else begin
      if (in_clk_tick && q.budget != '0) begin
        d.budget = q.budget - 10'h001; // RULE1
      end
      if (carry_pulse) begin
        if (q.sec_cnt == ctl.cal_prd) begin // RULE9
          d.sec_cnt = '0;
          d.budget  = ctl.cal_amt; // RULE2
        end else begin
          d.sec_cnt = q.sec_cnt + 6'h01;
        end
      end
    end
  end

  // Engine state is not a register; the soft reset restarts it instead
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) q <= '0;
    else     q <= d;
  end

  assign corrected_counter_clock = q.out;

  property p_mask;
    @(posedge sys_clk) disable iff (rst)
    ctl.cal_en && q.budget != '0 && in_clk_tick |=> !corrected_counter_clock;
  endproperty
  a_mask: assert property (p_mask) else $error("tick passed with budget left"); // RULE1
  property p_reload;
    @(posedge sys_clk) disable iff (rst)
    ctl.cal_en && !soft_rst && carry_pulse && q.sec_cnt == ctl.cal_prd
      |=> q.sec_cnt == '0 && q.budget == $past(ctl.cal_amt);
  endproperty
  a_reload: assert property (p_reload) else $error("period end not reloaded"); // RULE2
  property p_pass;
    @(posedge sys_clk) disable iff (rst)
    !ctl.cal_en |=> corrected_counter_clock == $past(in_clk_tick);
  endproperty
  a_pass: assert property (p_pass) else $error("uncorrected clock altered"); // RULE4
endmodule // rcd_trim

// [src/rcd_div.sv]
/*
  Power-of-two divider for the divided-clock pin, and the carry selector
  for the counter tick pin.
  Assumes in_clk_tick and carry_pulse are one-cycle enables on sys_clk.
*/
`timescale 1ns/1ps
module rcd_div
  import rcd_pkg::*;
(
  input  wire logic sys_clk,
  input  wire logic rst,
  input  wire logic soft_rst,
  input  wire logic in_clk_tick,
  input  wire logic carry_pulse,
  rcd_ctl_if.divr   ctl,
  output logic      divided_clock_pin,
  output logic      counter_tick_pin
);
  typedef struct packed {
    rcd_dv_state_t        st;
    logic [DIV_CNT_W-1:0] cnt;
    logic                 pin;
    logic                 half;
    logic                 tick;
  } rcd_div_st_t;
  rcd_div_st_t q, d;
  logic [DIV_CNT_W-1:0] lim;

  // Ticks per half period, less one
  assign lim = (15'h0001 << (ctl.div_ratio - 4'h1)) - 15'h0001;

  always_comb begin
    d = q;
    // Halved carry toggles on every carry pulse
    if (carry_pulse) d.half = ~q.half;
    d.tick = ctl.tick_sel ? d.half : carry_pulse; // RULE10
    case (q.st)
      RCD_DV_IDLE: begin
        d.pin = 1'b0; // RULE7
        if (ctl.div_en && !soft_rst) begin // RULE8
          d.st  = RCD_DV_RUN;
          d.cnt = '0;
        end
      end
      RCD_DV_RUN: begin
        // A cleared enable stops only at a low phase; soft_rst stops at once and forces the pin low
        if (soft_rst || (!ctl.div_en && !q.pin)) begin // RULE8
          d.st  = RCD_DV_IDLE;
          d.pin = 1'b0;
        end else if (ctl.div_ratio == '0) begin
          d.pin = in_clk_tick; // RULE5
        end else if (in_clk_tick) begin
          if (q.cnt >= lim) begin // RULE5
            d.cnt = '0;
            d.pin = ~q.pin;
          end else begin
            d.cnt = q.cnt + 15'h0001;
          end
        end
      end
      default: begin
        d.st  = RCD_DV_IDLE;
        d.pin = 1'b0;
      end
    endcase
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) q <= '{st: RCD_DV_IDLE, default: '0};
    else     q <= d;
  end

  assign ctl.div_running   = (q.st == RCD_DV_RUN); // RULE7
  assign divided_clock_pin = q.pin;
  assign counter_tick_pin  = q.tick;

  property p_low_idle;
    @(posedge sys_clk) disable iff (rst)
    !ctl.div_running |-> !divided_clock_pin;
  endproperty
  a_low_idle: assert property (p_low_idle) else $error("pin high while stopped"); // RULE7
  property p_stop;
    @(posedge sys_clk) disable iff (rst)
    !ctl.div_en && !divided_clock_pin |=> !ctl.div_running;
  endproperty
  a_stop: assert property (p_stop) else $error("divider did not stop"); // RULE8
  property p_direct;
    @(posedge sys_clk) disable iff (rst)
    !ctl.tick_sel |=> counter_tick_pin == $past(carry_pulse);
  endproperty
  a_direct: assert property (p_direct) else $error("carry not routed"); // RULE10
endmodule // rcd_div

// [tb/tb_top.sv]
/*
  Self-checking bench for the clock trim and divider block: AXI4-Lite
  register tasks, tick and carry stimulus, pulse counters on the pins.
  Assumes rcd_pkg is compiled first and the design answers per its note.
*/
`timescale 1ns/1ps
module tb_top
  import rcd_pkg::*;
;
  logic        sys_clk;
  logic        rst;
  logic        soft_rst;
  logic        in_clk_tick;
  logic        carry_pulse;
  logic [4:0]  awaddr;
  logic        awvalid;
  logic        awready;
  logic [31:0] wdata;
  logic [3:0]  wstrb;
  logic        wvalid;
  logic        wready;
  logic [1:0]  bresp;
  logic        bvalid;
  logic        bready;
  logic [4:0]  araddr;
  logic        arvalid;
  logic        arready;
  logic [31:0] rdata;
  logic [1:0]  rresp;
  logic        rvalid;
  logic        rready;
  logic        corr_clk;
  logic        div_pin;
  logic        tick_pin;
  logic        div_pin_p;
  logic        tick_pin_p;
  logic [31:0] rd_v;
  logic [1:0]  rd_r;
  int          fails;
  int          n_tests;
  int          n_corr;
  int          n_div;
  int          n_tk;
  // Plain registers: addresses and writable field masks
  logic [4:0]  ra [5] = '{ADDR_CAL_AMT, ADDR_CAL_EN, ADDR_DIV_RATIO, ADDR_CAL_PRD, ADDR_TICK_SEL};
  logic [31:0] rm [5] = '{32'h000003FF, 32'h00000001, 32'h0000000F, 32'h0000003F, 32'h00000001};
  int          rt [4] = '{0, 1, 3, 15};
  int          nt [4] = '{16, 16, 16, 32768};

  rcd_top dut (
    .sys_clk(sys_clk), .rst(rst), .soft_rst(soft_rst), .in_clk_tick(in_clk_tick),
    .carry_pulse(carry_pulse), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .corrected_counter_clock(corr_clk), .divided_clock_pin(div_pin),
    .counter_tick_pin(tick_pin)
  );

  // 50 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  // Pulse and rising-edge counters on the three pins
  always @(posedge sys_clk) begin
    div_pin_p  <= div_pin;
    tick_pin_p <= tick_pin;
    if (corr_clk === 1'b1) n_corr++;
    if (div_pin === 1'b1 && div_pin_p === 1'b0) n_div++;
    if (tick_pin === 1'b1 && tick_pin_p === 1'b0) n_tk++;
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic conclude();
    $display("comparisons=%0d mismatches=%0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // Handshakes are judged at the falling edge, so they match the next rising edge
  task automatic wr(input logic [4:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw_hs;
    logic w_hs;
    logic b_hs;
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    b_hs = 1'b0;
    // Waits as long as the slave needs; only the watchdog ends a hang
    while (!b_hs) begin
      @(negedge sys_clk);
      aw_hs = awvalid && awready === 1'b1;
      w_hs  = wvalid && wready === 1'b1;
      b_hs  = bvalid === 1'b1;
      if (b_hs) check({30'h0, bresp}, {30'h0, er});
      @(posedge sys_clk);
      if (aw_hs) awvalid <= 1'b0;
      if (w_hs) wvalid <= 1'b0;
      if (b_hs) bready <= 1'b0;
    end
    // Spare edge so a next call never re-raises bready in the same step
    @(posedge sys_clk);
  endtask

  task automatic rd(input logic [4:0] a, output logic [31:0] v, output logic [1:0] r);
    logic ar_hs;
    logic r_hs;
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    r_hs = 1'b0;
    v = 32'hFFFFFFFF;
    r = 2'h3;
    while (!r_hs) begin
      @(negedge sys_clk);
      ar_hs = arvalid && arready === 1'b1;
      r_hs  = rvalid === 1'b1;
      if (r_hs) begin
        v = rdata;
        r = rresp;
      end
      @(posedge sys_clk);
      if (ar_hs) arvalid <= 1'b0;
      if (r_hs) rready <= 1'b0;
    end
    // Spare edge so a next call never re-raises rready in the same step
    @(posedge sys_clk);
  endtask

  // Input clock ticks; gap 0 keeps the tick high every cycle
  task automatic tks(input int n, input int gap);
    repeat (n) begin
      in_clk_tick <= 1'b1;
      @(posedge sys_clk);
      if (gap > 0) begin
        in_clk_tick <= 1'b0;
        repeat (gap) @(posedge sys_clk);
      end
    end
    in_clk_tick <= 1'b0;
  endtask

  task automatic crr();
    carry_pulse <= 1'b1;
    @(posedge sys_clk);
    carry_pulse <= 1'b0;
    @(posedge sys_clk);
  endtask

  // One counted second with n input ticks
  task automatic sec(input int n);
    tks(n, 1);
    crr();
  endtask

  // Hang guard at 80k cycles, well beyond the roughly 34k the run needs
  initial begin
    #1600000;
    fails++;
    conclude();
  end

  initial begin
    fails = 0; n_tests = 0; n_corr = 0; n_div = 0; n_tk = 0;
    rst = 1'b1; soft_rst = 1'b0; in_clk_tick = 1'b0; carry_pulse = 1'b0;
    awaddr = 5'h00; awvalid = 1'b0; wdata = 32'h0; wvalid = 1'b0; bready = 1'b0;
    araddr = 5'h00; arvalid = 1'b0; rready = 1'b0;
    wstrb = 4'hF;
    repeat (20) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    // Reset values, then reserved bits stripped
    for (int i = 0; i < 5; i++) begin
      rd(ra[i], rd_v, rd_r);
      check(rd_v, 32'h0);
      wr(ra[i], 32'hFFFFFFFF, RESP_OKAY);
      rd(ra[i], rd_v, rd_r);
      check(rd_v, rm[i]);
    end
    rd(ADDR_DIV_CTL, rd_v, rd_r);
    check(rd_v, 32'h0);
    rd(5'h18, rd_v, rd_r);
    check({rd_v[29:0], rd_r}, {30'h0, RESP_SLVERR});
    wr(5'h1C, 32'h1, RESP_SLVERR);
    // Soft reset leaves every setting in place
    soft_rst <= 1'b1;
    repeat (3) @(posedge sys_clk);
    soft_rst <= 1'b0;
    @(posedge sys_clk);
    for (int i = 0; i < 5; i++) begin
      rd(ra[i], rd_v, rd_r);
      check(rd_v, rm[i]);
      wr(ra[i], 32'h0, RESP_OKAY);
    end
    // Upper byte lane alone reaches only amount bits 9:8
    wstrb <= 4'h2;
    wr(ADDR_CAL_AMT, 32'hFFFFFFFF, RESP_OKAY);
    wstrb <= 4'hF;
    rd(ADDR_CAL_AMT, rd_v, rd_r);
    check(rd_v, 32'h00000300);
    // Two-second period removing three ticks, two periods
    wr(ADDR_CAL_PRD, 32'h1, RESP_OKAY);
    wr(ADDR_CAL_AMT, 32'h3, RESP_OKAY);
    wr(ADDR_CAL_EN, 32'h1, RESP_OKAY);
    n_corr = 0;
    repeat (4) sec(10);
    repeat (3) @(posedge sys_clk);
    check(n_corr, 34);
    // Period 19, amount 8: eight ticks gone per twenty seconds
    wr(ADDR_CAL_EN, 32'h0, RESP_OKAY);
    wr(ADDR_CAL_PRD, 32'd19, RESP_OKAY);
    wr(ADDR_CAL_AMT, 32'h8, RESP_OKAY);
    wr(ADDR_CAL_EN, 32'h1, RESP_OKAY);
    n_corr = 0;
    repeat (20) sec(4);
    repeat (3) @(posedge sys_clk);
    check(n_corr, 72);
    // Masking off: every tick passes
    wr(ADDR_CAL_EN, 32'h0, RESP_OKAY);
    n_corr = 0;
    repeat (2) sec(10);
    repeat (3) @(posedge sys_clk);
    check(n_corr, 20);
    // Divider ratios, changed only while stopped
    for (int i = 0; i < 4; i++) begin
      wr(ADDR_DIV_RATIO, rt[i], RESP_OKAY);
      wr(ADDR_DIV_CTL, 32'h1, RESP_OKAY);
      repeat (3) @(posedge sys_clk);
      rd(ADDR_DIV_CTL, rd_v, rd_r);
      check(rd_v, 32'h3);
      n_div = 0;
      tks(nt[i], (rt[i] == 15) ? 0 : 1);
      repeat (3) @(posedge sys_clk);
      check(n_div, nt[i] >> rt[i]);
      wr(ADDR_DIV_CTL, 32'h0, RESP_OKAY);
      repeat (6) @(posedge sys_clk);
      rd(ADDR_DIV_CTL, rd_v, rd_r);
      check(rd_v, 32'h0);
      check(div_pin, 1'b0);
    end
    // Soft reset idles the divider but keeps its enable
    wr(ADDR_DIV_CTL, 32'h1, RESP_OKAY);
    repeat (3) @(posedge sys_clk);
    soft_rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    rd(ADDR_DIV_CTL, rd_v, rd_r);
    check(rd_v, 32'h1);
    check(div_pin, 1'b0);
    soft_rst <= 1'b0;
    repeat (3) @(posedge sys_clk);
    rd(ADDR_DIV_CTL, rd_v, rd_r);
    check(rd_v, 32'h3);
    wr(ADDR_DIV_CTL, 32'h0, RESP_OKAY);
    // Tick pin: carry as is, then halved
    n_tk = 0;
    repeat (4) crr();
    repeat (2) @(posedge sys_clk);
    check(n_tk, 4);
    wr(ADDR_TICK_SEL, 32'h1, RESP_OKAY);
    n_tk = 0;
    repeat (4) crr();
    repeat (2) @(posedge sys_clk);
    check(n_tk, 2);
    conclude();
  end
endmodule // tb_top
